// *** hw/lmp_pkg.sv ***
package lmp_pkg;

  // register byte addresses on the register bus
  localparam logic [15:0] LMP_ADDR_PHASE_POLARITY = 16'h2080;
  localparam logic [15:0] LMP_ADDR_CONTROL        = 16'h2100;
  localparam logic [15:0] LMP_ADDR_STATUS         = 16'h2104;
  localparam logic [15:0] LMP_ADDR_IRQ_STATUS     = 16'h2108;
  localparam logic [15:0] LMP_ADDR_IRQ_MASK       = 16'h210c;

  // phase/polarity setup fields, one hex digit each
  localparam int LMP_SENSOR_DIGIT_LSB = 0;
  localparam int LMP_PHASE_DIGIT_LSB  = 4;
  localparam int LMP_DIGIT_W          = 4;
  localparam logic [3:0] LMP_DIGIT_ZERO = 4'h0;
  localparam logic [3:0] LMP_DIGIT_ONE  = 4'h1;
  localparam logic [15:0] LMP_SETUP_RESET = 16'h0000;

  // control register bits
  localparam int LMP_CTL_RESTART    = 0;
  localparam int LMP_CTL_TOOL_REQ   = 1;
  localparam int LMP_CTL_UTIL_REQ   = 2;

  // status register bits
  localparam int LMP_ST_PHASE_B     = 0;
  localparam int LMP_ST_NO_SENSOR   = 1;
  localparam int LMP_ST_ANGLE_KNOWN = 2;
  localparam int LMP_ST_DETECTING   = 3;
  localparam int LMP_ST_SERVO_ON    = 4;
  localparam int LMP_ST_SENSOR_ALM  = 5;
  localparam int LMP_ST_READY_OK    = 6;

  // interrupt bits
  localparam int LMP_IRQ_DONE      = 0;
  localparam int LMP_IRQ_FAIL      = 1;
  localparam int LMP_IRQ_REFUSED   = 2;
  localparam int LMP_IRQ_SENS_ALM  = 3;
  localparam int LMP_IRQ_W         = 4;

  localparam logic [1:0] LMP_RESP_OKAY   = 2'b00;
  localparam logic [1:0] LMP_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    LMP_IDLE,
    LMP_RUN,
    LMP_ENABLED
  } lmp_state_type;

endpackage : lmp_pkg

// *** hw/lmp_axil_slave.sv ***
`timescale 1ns/1ps
// AXI4-Lite handshake: takes address and data in either order, one
// write and one read at a time; register decode lives in the parent
module lmp_axil_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [15:0] s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic             wr_en,
  output logic [15:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic [15:0]      rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  localparam logic [1:0] LMP_RESP_OKAY_L   = lmp_pkg::LMP_RESP_OKAY;
  localparam logic [1:0] LMP_RESP_SLVERR_L = lmp_pkg::LMP_RESP_SLVERR;

  logic        aw_have_q;
  logic        w_have_q;
  logic [15:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        ar_go;
  logic        aw_go;
  logic        w_go;
  logic        aw_have_d;
  logic        w_have_d;
  logic        bvalid_d;
  logic        rvalid_d;

  // readies are registered from the next slot state, so the top keeps
  // flop-driven outputs; ready still drops on the edge that fills a slot
  assign aw_go     = s_awvalid & s_awready;
  assign w_go      = s_wvalid & s_wready;
  assign wr_en     = aw_have_q & w_have_q & ~s_bvalid;
  assign aw_have_d = ~wr_en & (aw_have_q | aw_go);
  assign w_have_d  = ~wr_en & (w_have_q | w_go);
  assign bvalid_d  = wr_en | (s_bvalid & ~s_bready);
  assign ar_go     = s_arvalid & s_arready;
  assign rvalid_d  = ar_go | (s_rvalid & ~s_rready);
  assign wr_addr   = awaddr_q;
  assign wr_data   = wdata_q;
  assign wr_strb   = wstrb_q;
  assign rd_addr   = s_araddr;

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 16'h0000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= LMP_RESP_OKAY_L;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
    end else begin
      s_awready <= ~aw_have_d & ~bvalid_d;
      s_wready  <= ~w_have_d & ~bvalid_d;
      if (aw_go) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_awaddr;
      end
      if (w_go) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_wdata;
        wstrb_q  <= s_wstrb;
      end
      if (wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= wr_ok ? LMP_RESP_OKAY_L : LMP_RESP_SLVERR_L;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // read channel: data registered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= LMP_RESP_OKAY_L;
      s_arready <= 1'b0;
    end else begin
      s_arready <= ~rvalid_d;
      if (ar_go) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
        s_rresp  <= rd_ok ? LMP_RESP_OKAY_L : LMP_RESP_SLVERR_L;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
endmodule // lmp_axil_slave

// *** hw/lmp_polarity_setup.sv ***
`timescale 1ns/1ps
// Operation
// - phase digit 0 picks A-lead commutation, 1 picks B-lead, after restart
// - sensor digit 0 means sensor fitted, 1 means none, after restart
// - sensor configured but absent raises sensor fault alarm at power-up
// - incremental encoder without sensor loses detected angle at power-up
// - absolute encoder keeps detection result stored in the encoder
// - without sensor, servo-on refused until detection has succeeded
// - detection starts from servo-on (incremental only), tool or utility
// - start needs no-sensor, axes off, main power, no base block, no other or sensor fault alarm
// - start also needs motorless test off and no overtravel
// - servo-on started detection gives ready and enabled on completion
module lmp_polarity_setup
  import lmp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [15:0] s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  input  wire logic        servo_on_cmd,
  input  wire logic        other_axis_servo_on,
  input  wire logic        main_power_on,
  input  wire logic        hardwired_base_block,
  input  wire logic        other_alarm_active,
  input  wire logic        phase_info_mismatch_alarm,
  input  wire logic [3:0]  motorless_test_param,
  input  wire logic        overtravel,
  input  wire logic        encoder_absolute,
  input  wire logic        encoder_angle_stored,
  input  wire logic        sensor_present,
  input  wire logic        detect_done,
  input  wire logic        detect_fail,
  output logic             detect_start,
  output logic             store_to_encoder,
  output logic             phase_b_lead,
  output logic             servo_enable,
  output logic             servo_ready,
  output logic             polarity_sensor_fault_alarm,
  output logic             irq
);
  logic [15:0] setup_param_q;
  logic [15:0] active_param_q;
  logic        restart_q;
  logic        angle_known_q;
  logic        from_servo_q;
  logic [LMP_IRQ_W-1:0] irq_st_q;
  logic [LMP_IRQ_W-1:0] irq_mask_q;
  lmp_state_type state_q;
  lmp_state_type state_d;

  logic        wr_en;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;

  logic no_sensor;
  logic phase_b;
  logic prereq_ok;
  logic servo_req;
  logic tool_req;
  logic util_req;
  logic any_req;
  logic start_now;
  logic refused;
  logic servo_allowed;
  logic [LMP_IRQ_W-1:0] irq_set;
  logic [31:0] status_word;

  // one hex digit of a setup word
  function automatic logic [3:0] digit(input logic [15:0] w, input int lsb);
    digit = w[lsb +: LMP_DIGIT_W];
  endfunction

  // address match helper shared by read and write decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  lmp_axil_slave u_bus (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_ok     (wr_ok),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );

  // write decode; control register bits are self-clearing strobes
  wire wr_setup = wr_en & hit(wr_addr, LMP_ADDR_PHASE_POLARITY);
  wire wr_ctl   = wr_en & hit(wr_addr, LMP_ADDR_CONTROL);
  wire wr_ist   = wr_en & hit(wr_addr, LMP_ADDR_IRQ_STATUS);
  wire wr_imask = wr_en & hit(wr_addr, LMP_ADDR_IRQ_MASK);
  assign wr_ok = hit(wr_addr, LMP_ADDR_PHASE_POLARITY)
               | hit(wr_addr, LMP_ADDR_CONTROL)
               | hit(wr_addr, LMP_ADDR_STATUS)
               | hit(wr_addr, LMP_ADDR_IRQ_STATUS)
               | hit(wr_addr, LMP_ADDR_IRQ_MASK);
  assign tool_req = wr_ctl & wr_strb[0] & wr_data[LMP_CTL_TOOL_REQ];
  assign util_req = wr_ctl & wr_strb[0] & wr_data[LMP_CTL_UTIL_REQ];
  wire restart_req = wr_ctl & wr_strb[0] & wr_data[LMP_CTL_RESTART];

  // phase order from the latched copy only
  assign phase_b = digit(active_param_q, LMP_PHASE_DIGIT_LSB) == LMP_DIGIT_ONE;
  // sensor choice from the latched copy only
  assign no_sensor =
    digit(active_param_q, LMP_SENSOR_DIGIT_LSB) == LMP_DIGIT_ONE;

  assign prereq_ok = no_sensor & ~servo_enable & ~other_axis_servo_on
                   & main_power_on & ~hardwired_base_block
                   & ~other_alarm_active & ~polarity_sensor_fault_alarm
                   & (motorless_test_param == LMP_DIGIT_ZERO) & ~overtravel;

  // servo-on trigger only with incremental encoder and angle unknown
  assign servo_req = servo_on_cmd & ~encoder_absolute & no_sensor
                   & ~angle_known_q & ~servo_enable;
  assign any_req   = servo_req | tool_req | util_req;
  assign start_now = (state_q == LMP_IDLE) & any_req & prereq_ok;
  // a servo-on level is not counted as refused while it waits
  assign refused   = (tool_req | util_req) & ~start_now;

  // servo-on only with sensor or a known angle
  assign servo_allowed = (~no_sensor | angle_known_q)
                       & ~polarity_sensor_fault_alarm
                       & main_power_on & ~hardwired_base_block;

  // detection sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      LMP_IDLE: begin
        if (start_now) begin
          state_d = LMP_RUN;
        end
      end
      LMP_RUN: begin
        if (detect_done || detect_fail) begin
          state_d = LMP_IDLE;
        end
      end
      default: begin
        state_d = LMP_IDLE;
      end
    endcase
  end

  assign irq_set[LMP_IRQ_DONE]     = (state_q == LMP_RUN) & detect_done;
  assign irq_set[LMP_IRQ_FAIL]     = (state_q == LMP_RUN) & detect_fail
                                   & ~detect_done;
  assign irq_set[LMP_IRQ_REFUSED]  = refused;
  assign irq_set[LMP_IRQ_SENS_ALM] = restart_q & ~sensor_present
    & (digit(setup_param_q, LMP_SENSOR_DIGIT_LSB) == LMP_DIGIT_ZERO);

  // restart latches the stored setup; mirrors a power cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_param_q  <= LMP_SETUP_RESET;
      active_param_q <= LMP_SETUP_RESET;
      restart_q      <= 1'b1;
    end else begin
      if (wr_setup && wr_strb[0]) begin
        setup_param_q[7:0] <= wr_data[7:0];
      end
      if (wr_setup && wr_strb[1]) begin
        setup_param_q[15:8] <= wr_data[15:8];
      end
      restart_q <= restart_req;
      if (restart_q) begin
        active_param_q <= setup_param_q;
      end
    end
  end

  // sequencer state and completed-detection flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q       <= LMP_IDLE;
      angle_known_q <= 1'b0;
      from_servo_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start_now) begin
        from_servo_q <= servo_req;
      end
      if (irq_set[LMP_IRQ_DONE]) begin
        angle_known_q <= 1'b1;
      // angle lost at restart unless stored
      end else if (restart_q) begin
        angle_known_q <= encoder_absolute & encoder_angle_stored;
      end
    end
  end

  // outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_start                <= 1'b0;
      store_to_encoder            <= 1'b0;
      phase_b_lead                <= 1'b0;
      servo_enable                <= 1'b0;
      servo_ready                 <= 1'b0;
      polarity_sensor_fault_alarm <= 1'b0;
      irq                         <= 1'b0;
    end else begin
      detect_start <= start_now;
      // save result to the absolute encoder
      store_to_encoder <= irq_set[LMP_IRQ_DONE] & encoder_absolute;
      phase_b_lead <= phase_b;
      // fault latched at restart, cleared at next good restart
      if (irq_set[LMP_IRQ_SENS_ALM]) begin
        polarity_sensor_fault_alarm <= 1'b1;
      end else if (restart_q) begin
        polarity_sensor_fault_alarm <= 1'b0;
      end
      servo_ready <= servo_allowed;
      // servo-on started detection enables on completion
      if (irq_set[LMP_IRQ_DONE] && from_servo_q && servo_on_cmd) begin
        servo_enable <= 1'b1;
        servo_ready  <= 1'b1;
      end else if (!servo_on_cmd || !servo_allowed) begin
        servo_enable <= 1'b0;
      end else if (state_q == LMP_IDLE) begin
        servo_enable <= 1'b1;
      end
      irq <= |((irq_st_q | irq_set) & irq_mask_q);
    end
  end

  // sticky events; a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q   <= '0;
      irq_mask_q <= '0;
    end else begin
      if (wr_ist && wr_strb[0]) begin
        irq_st_q <= (irq_st_q & ~wr_data[LMP_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
      if (wr_imask && wr_strb[0]) begin
        irq_mask_q <= wr_data[LMP_IRQ_W-1:0];
      end
    end
  end

  // read decode
  assign status_word = {25'h0000000,
                        servo_ready,
                        polarity_sensor_fault_alarm,
                        servo_enable,
                        state_q == LMP_RUN,
                        angle_known_q,
                        no_sensor,
                        phase_b};
  wire rd_setup = hit(rd_addr, LMP_ADDR_PHASE_POLARITY);
  wire rd_ctl   = hit(rd_addr, LMP_ADDR_CONTROL);
  wire rd_st    = hit(rd_addr, LMP_ADDR_STATUS);
  wire rd_ist   = hit(rd_addr, LMP_ADDR_IRQ_STATUS);
  wire rd_imask = hit(rd_addr, LMP_ADDR_IRQ_MASK);
  assign rd_ok   = rd_setup | rd_ctl | rd_st | rd_ist | rd_imask;
  assign rd_data = rd_setup ? {16'h0000, setup_param_q}
                 : rd_st    ? status_word
                 : rd_ist   ? {28'h0000000, irq_st_q}
                 : rd_imask ? {28'h0000000, irq_mask_q}
                 : 32'h0000_0000;
endmodule // lmp_polarity_setup

// *** dv/lmp_polarity_setup_asserts.sv ***
`timescale 1ns/1ps
// port checker: bus handshakes and the detection start gate
module lmp_polarity_setup_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_awvalid,
  input wire logic       s_awready,
  input wire logic       s_wvalid,
  input wire logic       s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic       s_bvalid,
  input wire logic       s_bready,
  input wire logic       s_arvalid,
  input wire logic       s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic       s_rvalid,
  input wire logic       s_rready,
  input wire logic       servo_on_cmd,
  input wire logic       other_axis_servo_on,
  input wire logic       main_power_on,
  input wire logic       hardwired_base_block,
  input wire logic       other_alarm_active,
  input wire logic [3:0] motorless_test_param,
  input wire logic       overtravel,
  input wire logic       encoder_absolute,
  input wire logic       detect_done,
  input wire logic       detect_start,
  input wire logic       store_to_encoder,
  input wire logic       servo_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a start only follows a cycle with main power on and no base block, other axis servo-on or other alarm
  a_start_gated: assert property (
    detect_start |-> $past(main_power_on && !hardwired_base_block &&
      !other_axis_servo_on && !other_alarm_active))
    else $error("detection started while blocked");
  a_start_motorless: assert property (
    detect_start |-> $past(motorless_test_param == 4'h0 && !overtravel))
    else $error("detection started in test mode or overtravel");
  a_start_servo_off: assert property (
    detect_start |-> !servo_enable && !$past(servo_enable))
    else $error("detection started with servo on");
  a_start_pulse: assert property (
    detect_start |=> !detect_start)
    else $error("start pulse longer than one cycle");
  a_servo_cause: assert property (
    $rose(servo_enable) |-> $past(servo_on_cmd))
    else $error("servo enabled without command");
  a_store_cause: assert property (
    store_to_encoder |-> $past(detect_done && encoder_absolute))
    else $error("store without absolute completion");
  a_write_latency: assert property (
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("write response late");
  a_read_latency: assert property (
    s_arvalid && s_arready |=> s_rvalid)
    else $error("read response late");
  a_resp_hold: assert property (
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata) && !s_arready)
    else $error("read data dropped");
endmodule // lmp_polarity_setup_asserts

// *** dv/lmp_engine_model.sv ***
`timescale 1ns/1ps
// detection engine and encoder stand-in; answers each start after a nonzero
// programmable delay (a delay of 0 never answers) so both prompt and slow replies are exercised
module lmp_engine_model #(
  parameter int PITCH_UM = 20
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       detect_start,
  input  wire logic       fail_req,
  input  wire logic [7:0] delay,
  output logic            detect_done,
  output logic            detect_fail
);
  int cnt_q;

  // one run at a time, result pulses last one cycle
  always_ff @(posedge aclk) begin
    detect_done <= 1'b0;
    detect_fail <= 1'b0;
    if (!aresetn) begin
      cnt_q <= 0;
    end else if (detect_start) begin
      cnt_q <= int'(delay);
    end else if (cnt_q == 1) begin
      cnt_q <= 0;
      detect_fail <= fail_req;
      detect_done <= !fail_req;
    end else if (cnt_q > 1) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule // lmp_engine_model

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
  import lmp_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, s_awvalid = 1'b0;
  logic        s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0;
  logic        s_rready = 1'b0, servo_on_cmd = 1'b0, overtravel = 1'b0;
  logic        other_axis_servo_on = 1'b0, main_power_on = 1'b1;
  logic        hardwired_base_block = 1'b0, other_alarm_active = 1'b0;
  logic        phase_info_mismatch_alarm = 1'b0, encoder_absolute = 1'b0;
  logic        encoder_angle_stored = 1'b0, sensor_present = 1'b0;
  logic        fail_req = 1'b0;
  logic [15:0] s_awaddr = 16'h0000, s_araddr = 16'h0000;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd, m_irq, m_st;
  logic [3:0]  s_wstrb = 4'hf, motorless_test_param = 4'h0;
  logic [7:0]  eng_delay = 8'h02;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic        detect_done, detect_fail, detect_start, store_to_encoder;
  logic        phase_b_lead, servo_enable, servo_ready, irq;
  logic        polarity_sensor_fault_alarm;
  int          mismatches = 0, checks_done = 0, seed = 19162;
  int          starts = 0, stores = 0, i;

  lmp_polarity_setup uut (.*);
  lmp_engine_model eng (.aclk, .aresetn, .detect_start, .fail_req,
    .delay(eng_delay), .detect_done, .detect_fail);

  initial begin
    forever #25 aclk = ~aclk;
  end

  // count engine starts and encoder stores seen at the ports
  always @(posedge aclk) begin
    if (detect_start === 1'b1) starts <= starts + 1;
    if (store_to_encoder === 1'b1) stores <= stores + 1;
  end

  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // a wait that runs out counts against the run and ends it
  task timeout;
    mismatches++;
    give_verdict();
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid === 1'b1) break;
    end
    rsp = s_bresp;
    s_bready <= 1'b0;
    if (n == 40) timeout();
  endtask

  task rdr(input logic [15:0] a);
    int n;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid === 1'b1) break;
    end
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
    if (n == 40) timeout();
  endtask

  task wait_eng;
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (detect_done || detect_fail) break;
    end
    if (n == 100) timeout();
    tick(2);
  endtask

  initial begin
    tick(2);
    aresetn <= 1'b1;
    tick(4);
    // sensor expected by default but absent
    chk(polarity_sensor_fault_alarm, 32'h1);
    m_st = 32'h20;
    m_irq = 32'h8;
    rdr(LMP_ADDR_STATUS);
    chk(rd, m_st);
    rdr(LMP_ADDR_IRQ_STATUS);
    chk(rd, m_irq);
    chk(irq, 32'h0);
    wr(LMP_ADDR_IRQ_MASK, 32'hf);
    chk(32'(rsp), 32'h0);
    tick(2);
    chk(irq, 32'h1);
    // no sensor and b lead, held back until restart
    wr(LMP_ADDR_PHASE_POLARITY, 32'h11);
    chk(phase_b_lead, 32'h0);
    rdr(LMP_ADDR_PHASE_POLARITY);
    chk(rd, 32'h11);
    wr(LMP_ADDR_CONTROL, 32'h1);
    tick(3);
    chk(phase_b_lead, 32'h1);
    chk(polarity_sensor_fault_alarm, 32'h0);
    m_st = 32'h3;
    rdr(LMP_ADDR_STATUS);
    chk(rd, m_st);
    wr(LMP_ADDR_IRQ_STATUS, 32'hf);
    rdr(LMP_ADDR_IRQ_STATUS);
    chk(rd, 32'h0);
    // one blocker per pass; last pass sets only the non-blocking phase mismatch alarm and the engine fails
    for (i = 0; i < 7; i++) begin
      other_axis_servo_on <= (i == 0);
      main_power_on <= (i != 1);
      hardwired_base_block <= (i == 2);
      other_alarm_active <= (i == 3);
      overtravel <= (i == 4);
      motorless_test_param <= (i == 5) ?
        4'h1 + 4'($unsigned($random(seed)) % 15) : 4'h0;
      phase_info_mismatch_alarm <= (i == 6);
      fail_req <= 1'b1;
      // setup writes are never locked here, so each request is legal
      wr(LMP_ADDR_CONTROL, (i == 6) ? 32'h4 : 32'h2);
      if (i == 6) wait_eng();
      else tick(3);
      m_irq = (i == 6) ? 32'h2 : 32'h4;
      rdr(LMP_ADDR_IRQ_STATUS);
      chk(rd, m_irq);
      wr(LMP_ADDR_IRQ_STATUS, m_irq);
    end
    chk(32'(starts), 32'h1);
    // servo-on start with a slow engine reply
    fail_req <= 1'b0;
    phase_info_mismatch_alarm <= 1'b0;
    eng_delay <= 8'h0c;
    servo_on_cmd <= 1'b1;
    tick(4);
    chk(servo_enable, 32'h0);
    wait_eng();
    chk(servo_ready, 32'h1);
    m_st = 32'h57;
    rdr(LMP_ADDR_STATUS);
    chk(rd, m_st);
    rdr(LMP_ADDR_IRQ_STATUS);
    chk(rd, 32'h1);
    wr(LMP_ADDR_IRQ_STATUS, 32'h1);
    // incremental angle is lost on restart
    servo_on_cmd <= 1'b0;
    tick(2);
    wr(LMP_ADDR_CONTROL, 32'h1);
    tick(2);
    rdr(LMP_ADDR_STATUS);
    chk(rd & 32'hf, 32'h3);
    // absolute encoder stores and keeps the angle
    encoder_absolute <= 1'b1;
    eng_delay <= 8'h02;
    wr(LMP_ADDR_CONTROL, 32'h4);
    wait_eng();
    chk(32'(stores), 32'h1);
    encoder_angle_stored <= 1'b1;
    wr(LMP_ADDR_CONTROL, 32'h1);
    tick(2);
    rdr(LMP_ADDR_STATUS);
    chk(rd & 32'hf, 32'h7);
    // unmapped place answers with an error and zero data
    rdr(16'h2200);
    chk(32'(rsp), 32'h2);
    chk(rd, 32'h0);
    give_verdict();
  end
endmodule // tb

bind lmp_polarity_setup lmp_polarity_setup_asserts u_chk (.aclk,
  .aresetn, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bresp,
  .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata, .s_rvalid,
  .s_rready, .servo_on_cmd, .other_axis_servo_on, .main_power_on,
  .hardwired_base_block, .other_alarm_active, .motorless_test_param,
  .overtravel, .encoder_absolute, .detect_done, .detect_start,
  .store_to_encoder, .servo_enable);
